/* fosr_host_model.sv */
// host memory controller model driving the asynchronous status bus
`timescale 1ns/10ps
module fosr_host_model (
   // clock
   input  wire logic       clk_in,
   // bus pins
   input  wire logic [7:0] data_in,
   input  wire logic [7:0] data_oe_in,
   output logic            chip_en_n_out,
   output logic            out_en_n_out,
   output logic [7:0]      code_out,
   output logic            write_out
);
   // idle bus: deselected, no write
   initial begin
      chip_en_n_out = 1'b1;
      out_en_n_out  = 1'b1;
      code_out      = 8'h00;
      write_out     = 1'b0;
   end

   // one bus write; released code lines show the inverse value
   task automatic write_cmd(input logic [7:0] code);
      @(posedge clk_in);
      code_out  <= code;
      write_out <= 1'b1;
      @(posedge clk_in);
      code_out  <= ~code;
      write_out <= 1'b0;
   endtask

   // asynchronous read: select, let the pin synchronisers settle, sample, deselect
   task automatic read_stat(output logic [7:0] d, output logic [7:0] oe);
      @(posedge clk_in);
      chip_en_n_out <= 1'b0;
      out_en_n_out  <= 1'b0;
      repeat (6) @(posedge clk_in);
      #1;
      d  = data_in ^ ~data_oe_in; // undriven lines read back inverted
      oe = data_oe_in;
      @(posedge clk_in);
      chip_en_n_out <= 1'b1;
      out_en_n_out  <= 1'b1;
      repeat (3) @(posedge clk_in);
   endtask

   // poll the ready bit, only then trust the rest; reserved bit masked
   task automatic poll_ready(output logic [7:0] d, output logic ok);
      logic [7:0] oe;
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         read_stat(d, oe);
         ok = (d[7] === 1'b1);
      end
      d[0] = 1'b0;
   endtask
endmodule

/* fosr_pkg.sv */
// package for the flash operation status register block
package fosr_pkg;

   // status bit positions
   localparam int unsigned BIT_CTRL_READY   = 7;
   localparam int unsigned BIT_ERASE_SUSP   = 6;
   localparam int unsigned BIT_ERASE_FAIL   = 5;
   localparam int unsigned BIT_PROG_FAIL    = 4;
   localparam int unsigned BIT_SUPPLY_ERR   = 3;
   localparam int unsigned BIT_PROG_SUSP    = 2;
   localparam int unsigned BIT_PROT_ERR     = 1;

   // command codes seen on the low byte of a bus write
   localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
   localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;

   // values after reset
   localparam logic [3:0] STICKY_RESET      = 4'h0;
   localparam logic [7:0] SNAP_RESET        = 8'h80;
   localparam logic       SEL_N_RESET       = 1'b1;   // idle level of active-low select pins

   // operation kinds started by the command decoder
   typedef enum logic [2:0] {
      OP_NONE,
      OP_PROGRAM,
      OP_ERASE,
      OP_PROTECT,
      OP_UNPROTECT
   } fosr_op_e;

   // outcome reported by the program/erase controller at the end of an operation
   typedef struct packed {
      logic limit_fail;   // pulse limit exhausted
      logic seq_fail;     // wrong command sequence
      logic prot_block;   // target block protected
   } fosr_result_s;

   // command pulses from the command decoder
   typedef struct packed {
      logic     start;       // operation accepted
      fosr_op_e op;          // kind of operation started
      logic     suspend;     // suspend accepted
      logic     resume;      // resume accepted
      logic     read_status; // read status accepted
      logic     clear;       // clear status accepted
      logic     read_array;  // back to array read
   } fosr_cmd_s;

endpackage

/* fosr_sticky.sv */
// sticky error bits with clear command
`timescale 1ns/10ps
module fosr_sticky #(
   parameter int unsigned WIDTH = 4
) (
   // clock and reset
   input  wire logic             CLK_SYS_IN,
   input  wire logic             SYS_RST_IN,
   // set and clear
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } fosr_stk_s;

   fosr_stk_s st_r;
   fosr_stk_s st_nxt;

   // set wins over clear so no event is lost
   always_comb begin
      st_nxt = st_r;
      if (clear_in) begin
         st_nxt.flags = '0;
      end
      st_nxt.flags = st_nxt.flags | set_in;
   end

   // hold flags; reset clears them
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         st_r.flags <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flags_out = st_r.flags;

endmodule

/* fosr_sync.sv */
// two flip-flop synchroniser for a single pin level
`timescale 1ns/10ps
module fosr_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic CLK_SYS_IN,
   input  wire logic SYS_RST_IN,
   // level
   input  wire logic d_in,
   output logic      q_out
);

   typedef struct packed {
      logic meta;
      logic q;
   } fosr_sync_s;

   fosr_sync_s st_r;
   fosr_sync_s st_nxt;

   // first stage feeds only the second stage
   always_comb begin
      st_nxt.meta = d_in;
      st_nxt.q    = st_r.meta;
   end

   // register the pair
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         // reset to the pin's idle level so no false edge follows reset
         st_r.meta <= RESET_VAL;
         st_r.q    <= RESET_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_out = st_r.q;

endmodule

/* fosr_top.sv */
// operation status register of the flash: state, errors and read path
// Behaviour
// R1: status appears on the low eight data lines
// R2: program, erase, protect, resume commands select status read
// R3: status read ignores the presented address
// R4: status only by async reads; array restores burst
// R5: display refreshes on output enable or chip toggle
// R6: bits 5,4,3,1 stay until clear command
// R7: hardware reset clears all sticky error bits
// R8: bit 7 low busy, others float
// R9: after suspend bit 7 low until paused
// R10: host polls bit 7 before other bits
// R11: bit 6 shows erase suspended awaiting resume
// R12: resume clears erase suspend bit
// R13: bit 2 shows program suspended, resume clears
// R14: bit 5 flags erase or unprotect failure
// R15: erase failure cause adds bits 3, 1, 4
// R16: bit 4 flags program or protect failure
// R17: program failure cause adds bits 3, 1, 5
// R18: supply sampled at operation start, sets bit 3
// R19: protected block adds bit 1 with failure
// R20: set error makes new operation fail
// R21: host masks reserved bit 0
// R22: program during erase suspend reports bit 6
// R23: protect operations accept only read status
// R24: read status 70h, clear status 50h
`timescale 1ns/10ps
module fosr_top (
   // clock and reset
   input  wire logic                CLK_SYS_IN,
   input  wire logic                SYS_RST_IN,
   // command decoder pulses
   input  wire fosr_pkg::fosr_cmd_s CMD_IN,
   input  wire logic [7:0]          CMD_CODE_IN,
   input  wire logic                CMD_WRITE_IN,
   // program/erase controller
   input  wire logic                CTRL_PAUSED_IN,
   input  wire logic                CTRL_DONE_IN,
   input  wire fosr_pkg::fosr_result_s CTRL_RESULT_IN,
   input  wire logic                BLOCK_PROT_IN,
   // pins from outside the clock domain
   input  wire logic                WP_SUPPLY_OK_IN,
   input  wire logic                CHIP_EN_N_IN,
   input  wire logic                OUT_EN_N_IN,
   input  wire logic                SYNC_READ_CFG_IN,
   // read path, controller requests and ignored-command flag
   output logic [7:0]               LOW_BYTE_DATA_LINES_OUT,
   output logic [7:0]               LOW_BYTE_DATA_LINES_OE_OUT,
   output logic                     STATUS_MODE_OUT,
   output logic                     SYNC_READ_EN_OUT,
   output logic                     CTRL_GO_OUT,
   output logic                     CTRL_SUSPEND_OUT,
   output logic                     CTRL_RESUME_OUT,
   output logic                     CMD_IGNORED_OUT
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_SUSP_WAIT,
      ST_SUSPENDED,
      ST_NESTED_PROG
   } fosr_state_e;

   typedef struct packed {
      fosr_state_e      state;
      fosr_pkg::fosr_op_e op;
      fosr_pkg::fosr_op_e susp_op;
      logic             status_mode;
      logic             erase_susp;
      logic             prog_susp;
      logic [7:0]       snap;
      logic             oe_n_d;
      logic             ce_n_d;
      logic             go;
      logic             ignored;
   } fosr_state_s;

   fosr_state_s st_r;
   fosr_state_s st_nxt;

   logic       wp_ok;
   logic       ce_n;
   logic       oe_n;
   logic       sync_cfg;
   logic [3:0] sticky_set;
   logic       sticky_clr;
   logic [3:0] sticky;
   logic [7:0] live;
   logic       busy;
   logic       locked;
   logic       refresh;

   // error flag order inside sticky vector: erase, program, supply, protection
   function automatic logic [3:0] fail_bits(input fosr_pkg::fosr_op_e op,
                                            input fosr_pkg::fosr_result_s res,
                                            input logic prior);
      logic erase_like;
      logic [3:0] b;
      erase_like = (op == fosr_pkg::OP_ERASE) || (op == fosr_pkg::OP_UNPROTECT);
      b = 4'h0;
      if (res.limit_fail || prior) begin
         b[3] = erase_like;                                  // [R14] [R20]
         b[2] = !erase_like;                                 // [R16]
      end
      if (res.seq_fail) begin
         b[3] = 1'b1;                                        // [R15] [R17]
         b[2] = 1'b1;
      end
      return b;
   endfunction

   // pins pass two flip-flops before use
   fosr_sync u_sync_wp (
      .CLK_SYS_IN (CLK_SYS_IN),
      .SYS_RST_IN (SYS_RST_IN),
      .d_in       (WP_SUPPLY_OK_IN),
      .q_out      (wp_ok)
   );
   fosr_sync #(
      .RESET_VAL (fosr_pkg::SEL_N_RESET)
   ) u_sync_ce (
      .CLK_SYS_IN (CLK_SYS_IN),
      .SYS_RST_IN (SYS_RST_IN),
      .d_in       (CHIP_EN_N_IN),
      .q_out      (ce_n)
   );
   fosr_sync #(
      .RESET_VAL (fosr_pkg::SEL_N_RESET)
   ) u_sync_oe (
      .CLK_SYS_IN (CLK_SYS_IN),
      .SYS_RST_IN (SYS_RST_IN),
      .d_in       (OUT_EN_N_IN),
      .q_out      (oe_n)
   );
   fosr_sync u_sync_cfg (
      .CLK_SYS_IN (CLK_SYS_IN),
      .SYS_RST_IN (SYS_RST_IN),
      .d_in       (SYNC_READ_CFG_IN),
      .q_out      (sync_cfg)
   );

   // sticky errors cleared by command or hardware reset
   fosr_sticky #(
      .WIDTH (4)
   ) u_sticky (
      .CLK_SYS_IN (CLK_SYS_IN),
      .SYS_RST_IN (SYS_RST_IN),                              // [R7]
      .set_in     (sticky_set),
      .clear_in   (sticky_clr),                              // [R6]
      .flags_out  (sticky)
   );

   // controller busy and protect lock-out
   always_comb begin
      busy   = (st_r.state == ST_RUN) || (st_r.state == ST_SUSP_WAIT) || (st_r.state == ST_NESTED_PROG);
      locked = busy && ((st_r.op == fosr_pkg::OP_PROTECT) || (st_r.op == fosr_pkg::OP_UNPROTECT));
   end

   // clear status on code 50h, refused during protect operations
   always_comb begin
      sticky_clr = (CMD_IN.clear || (CMD_WRITE_IN && (CMD_CODE_IN == fosr_pkg::CMD_CLEAR_STATUS)))
                   && !locked;                                            // [R24] [R23]
   end

   // live status assembled from state and sticky errors
   always_comb begin
      live = 8'h00;
      live[fosr_pkg::BIT_CTRL_READY] = !busy;                           // [R8] [R9]
      live[fosr_pkg::BIT_ERASE_SUSP] = st_r.erase_susp;                 // [R11] [R22]
      live[fosr_pkg::BIT_ERASE_FAIL] = sticky[3];
      live[fosr_pkg::BIT_PROG_FAIL]  = sticky[2];
      live[fosr_pkg::BIT_SUPPLY_ERR] = sticky[1];
      live[fosr_pkg::BIT_PROG_SUSP]  = st_r.prog_susp;                  // [R13]
      live[fosr_pkg::BIT_PROT_ERR]   = sticky[0];
   end

   // new value latched on output enable toggle, chip re-select, or every cycle while not busy
   always_comb begin
      refresh = (oe_n != st_r.oe_n_d) || (st_r.ce_n_d && !ce_n && !oe_n) || !busy; // [R5]
   end

   // state update
   always_comb begin
      st_nxt         = st_r;
      st_nxt.oe_n_d  = oe_n;
      st_nxt.ce_n_d  = ce_n;
      st_nxt.go      = 1'b0;
      st_nxt.ignored = 1'b0;
      sticky_set     = 4'h0;
      if (refresh) begin
         st_nxt.snap = live;
      end
      if (locked) begin
         // only read status passes while protect runs
         if (CMD_IN.start || CMD_IN.suspend || CMD_IN.resume || CMD_IN.read_array || CMD_IN.clear
             || (CMD_WRITE_IN && CMD_CODE_IN == fosr_pkg::CMD_CLEAR_STATUS)) begin
            st_nxt.ignored = 1'b1;                                      // [R23]
         end
      end else begin
         if (CMD_IN.read_status || (CMD_WRITE_IN && CMD_CODE_IN == fosr_pkg::CMD_READ_STATUS)) begin
            st_nxt.status_mode = 1'b1;                                  // [R24]
         end
         if (CMD_IN.read_array || (CMD_WRITE_IN && CMD_CODE_IN == fosr_pkg::CMD_READ_ARRAY)) begin
            st_nxt.status_mode = 1'b0;                                  // [R4]
         end
      end
      case (st_r.state)
         ST_IDLE, ST_SUSPENDED: begin
            if (CMD_IN.start && CMD_IN.op != fosr_pkg::OP_NONE) begin
               st_nxt.status_mode = 1'b1;                               // [R2]
               st_nxt.op          = CMD_IN.op;
               if (!wp_ok) begin
                  sticky_set[1] = 1'b1;                                 // [R18]
                  sticky_set    = sticky_set | fail_bits(CMD_IN.op, '0, 1'b1);
               end else if (sticky != 4'h0) begin
                  sticky_set = fail_bits(CMD_IN.op, '0, 1'b1);          // [R20]
               end else if (BLOCK_PROT_IN && (CMD_IN.op == fosr_pkg::OP_PROGRAM
                                               || CMD_IN.op == fosr_pkg::OP_ERASE)) begin
                  sticky_set = fail_bits(CMD_IN.op, '0, 1'b1) | 4'h1;   // [R19] [R15] [R17]
               end else begin
                  st_nxt.go    = 1'b1;
                  st_nxt.state = (st_r.state == ST_SUSPENDED) ? ST_NESTED_PROG : ST_RUN;
               end
            end else if (CMD_IN.resume && st_r.state == ST_SUSPENDED) begin
               st_nxt.status_mode = 1'b1;                               // [R2]
               st_nxt.erase_susp  = 1'b0;                               // [R12]
               st_nxt.prog_susp   = 1'b0;                               // [R13]
               st_nxt.op          = st_r.susp_op;
               st_nxt.state       = ST_RUN;
            end
         end
         ST_RUN: begin
            if (CTRL_DONE_IN) begin
               st_nxt.susp_op = fosr_pkg::OP_NONE;                      // resumed op finished
               sticky_set   = fail_bits(st_r.op, CTRL_RESULT_IN, 1'b0);
               st_nxt.state = ST_IDLE;
            end else if (CMD_IN.suspend && !locked) begin
               st_nxt.state = ST_SUSP_WAIT;                             // [R9]
            end
         end
         ST_SUSP_WAIT: begin
            if (CTRL_DONE_IN) begin
               // completed instead of pausing
               st_nxt.susp_op = fosr_pkg::OP_NONE;
               sticky_set   = fail_bits(st_r.op, CTRL_RESULT_IN, 1'b0);
               st_nxt.state = ST_IDLE;
            end else if (CTRL_PAUSED_IN) begin
               st_nxt.susp_op    = st_r.op;
               st_nxt.erase_susp = (st_r.op == fosr_pkg::OP_ERASE);     // [R11]
               st_nxt.prog_susp  = (st_r.op == fosr_pkg::OP_PROGRAM);   // [R13]
               st_nxt.state      = ST_SUSPENDED;
            end
         end
         ST_NESTED_PROG: begin
            if (CTRL_DONE_IN) begin
               sticky_set   = fail_bits(st_r.op, CTRL_RESULT_IN, 1'b0);
               st_nxt.state = ST_SUSPENDED;                             // [R22]
            end
         end
         default: begin
            st_nxt.state = ST_IDLE;
         end
      endcase
   end

   // register all state
   always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         st_r.state       <= ST_IDLE;
         st_r.op          <= fosr_pkg::OP_NONE;
         st_r.susp_op     <= fosr_pkg::OP_NONE;
         st_r.status_mode <= 1'b0;
         st_r.erase_susp  <= 1'b0;
         st_r.prog_susp   <= 1'b0;
         st_r.snap        <= fosr_pkg::SNAP_RESET;
         st_r.oe_n_d      <= 1'b1;
         st_r.ce_n_d      <= 1'b1;
         st_r.go          <= 1'b0;
         st_r.ignored     <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // status on low byte regardless of address; bits 6 to 0 float while busy
   always_comb begin
      LOW_BYTE_DATA_LINES_OUT    = st_r.snap;                           // [R1] [R3]
      LOW_BYTE_DATA_LINES_OE_OUT = 8'h00;
      if (st_r.status_mode && !ce_n && !oe_n) begin
         LOW_BYTE_DATA_LINES_OE_OUT = st_r.snap[fosr_pkg::BIT_CTRL_READY] ? 8'hFF : 8'h80; // [R8]
      end
   end

   // burst setting only outside status mode
   assign SYNC_READ_EN_OUT = sync_cfg && !st_r.status_mode;             // [R4]
   assign STATUS_MODE_OUT  = st_r.status_mode;
   assign CTRL_GO_OUT      = st_r.go;
   assign CTRL_SUSPEND_OUT = (st_r.state == ST_SUSP_WAIT);
   assign CTRL_RESUME_OUT  = (st_r.state == ST_RUN) && (st_r.susp_op != fosr_pkg::OP_NONE);
   assign CMD_IGNORED_OUT  = st_r.ignored;

   // checks
   clear_wins_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      sticky_clr && sticky_set == 4'h0 |=> sticky == 4'h0) else $error("clear did not empty errors"); // [R6]
   sticky_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      !sticky_clr && sticky[3] |=> sticky[3]) else $error("erase error dropped"); // [R6]
   busy_low_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      busy && refresh |=> !LOW_BYTE_DATA_LINES_OUT[7]) else $error("ready bit high while busy"); // [R8]
   susp_wait_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      st_r.state == ST_SUSP_WAIT && !CTRL_PAUSED_IN && !CTRL_DONE_IN |=> !live[7]) else $error("ready before pause"); // [R9]
   resume_clr_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      st_r.state == ST_SUSPENDED && CMD_IN.resume && !CMD_IN.start |=> !st_r.erase_susp && !st_r.prog_susp)
      else $error("suspend bits kept after resume"); // [R12]
   supply_err_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      st_r.state == ST_IDLE && CMD_IN.start && CMD_IN.op != fosr_pkg::OP_NONE && !wp_ok |=> sticky[1])
      else $error("supply error not flagged"); // [R18]
   status_sel_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      !locked && CMD_IN.start && CMD_IN.op != fosr_pkg::OP_NONE |=> st_r.status_mode) else $error("no status mode"); // [R2]
   float_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      !st_r.snap[7] |-> LOW_BYTE_DATA_LINES_OE_OUT[6:0] == 7'h00) else $error("status bits driven while busy"); // [R8]
   fail_start_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
      st_r.state == ST_IDLE && CMD_IN.start && sticky != 4'h0 |=> st_r.state == ST_IDLE && !st_r.go)
      else $error("operation started with errors set"); // [R20]
   susp_c: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) st_r.state == ST_SUSPENDED);
   nest_c: cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) st_r.state == ST_NESTED_PROG);
   err_c:  cover property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN) sticky[3] && sticky[0]);

endmodule

/* fosr_top_tb.sv */
// self-checking testbench of the flash operation status register
`timescale 1ns/10ps
module fosr_top_tb;
   logic                   clk, rst, done, paused, prot, wp_ok, sync_cfg;
   fosr_pkg::fosr_cmd_s    cmd;
   fosr_pkg::fosr_result_s res;
   logic [7:0]             code, dq, dq_oe, d, oe;
   logic                   ce_n, oe_n, wr, stat_mode, sync_en, go, susp, resm, ign, ok;
   int                     errors, samples_checked;

   fosr_top fosr_top_inst (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CMD_IN(cmd), .CMD_CODE_IN(code),
      .CMD_WRITE_IN(wr), .CTRL_PAUSED_IN(paused), .CTRL_DONE_IN(done), .CTRL_RESULT_IN(res),
      .BLOCK_PROT_IN(prot), .WP_SUPPLY_OK_IN(wp_ok), .CHIP_EN_N_IN(ce_n), .OUT_EN_N_IN(oe_n),
      .SYNC_READ_CFG_IN(sync_cfg), .LOW_BYTE_DATA_LINES_OUT(dq), .LOW_BYTE_DATA_LINES_OE_OUT(dq_oe),
      .STATUS_MODE_OUT(stat_mode), .SYNC_READ_EN_OUT(sync_en), .CTRL_GO_OUT(go),
      .CTRL_SUSPEND_OUT(susp), .CTRL_RESUME_OUT(resm), .CMD_IGNORED_OUT(ign));

   fosr_host_model fosr_host_model_inst (.clk_in(clk), .data_in(dq), .data_oe_in(dq_oe),
      .chip_en_n_out(ce_n), .out_en_n_out(oe_n), .code_out(code), .write_out(wr));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // compare one result and count it
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // decoder pulse flags: suspend, resume, read status, clear, array
   function automatic fosr_pkg::fosr_cmd_s mk(logic s, fosr_pkg::fosr_op_e o, logic [4:0] f);
      return '{s, o, f[4], f[3], f[2], f[1], f[0]};
   endfunction

   // one-cycle decoder pulse, returns just after the taking edge
   task automatic pulse(input fosr_pkg::fosr_cmd_s c);
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask

   // bus write with the matching decoder pulse
   task automatic send(input fosr_pkg::fosr_cmd_s c, input logic [7:0] cd);
      fork
         fosr_host_model_inst.write_cmd(cd);
         pulse(c);
      join
   endtask

   // one-cycle controller event: finished with result, or paused
   task automatic fin(input logic [2:0] r, input logic is_pause);
      @(posedge clk);
      done   <= ~is_pause;
      paused <= is_pause;
      res    <= fosr_pkg::fosr_result_s'(r);
      @(posedge clk);
      done   <= 1'b0;
      paused <= 1'b0;
      res    <= '0;
   endtask

   // clear sticky errors before each new operation
   task automatic clear_st();
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00010), 8'h50);
   endtask

   // erase running then failing on the pulse limit; sticky until clear
   task automatic t_erase_limit();
      pulse(mk(1'b1, fosr_pkg::OP_ERASE, 5'b0));
      chk(go, 1'b1);
      chk(stat_mode, 1'b1);
      fosr_host_model_inst.read_stat(d, oe);
      chk(d[7], 1'b0);
      chk({oe[7:1], 1'b0}, 8'h80);
      fin(3'b100, 1'b0);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'hA0);
      pulse(mk(1'b1, fosr_pkg::OP_PROGRAM, 5'b0));
      chk(go, 1'b0);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00001), 8'hFF);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00100), 8'h70);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d[5], 1'b1);
      clear_st();
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h80);
   endtask

   // every operation kind against supply outcomes, all but erase against pulse limit, program and erase also against sequence failure and protection
   task automatic t_causes();
      logic [15:0] tbl [13] = '{16'h2098, 16'h3892, 16'h40A8, 16'h58A2, 16'h32B0, 16'h52B0, 16'h3490,
                                16'h5080, 16'h7490, 16'h6098, 16'h94A0, 16'h80A8, 16'h3080};
      logic        g;
      foreach (tbl[i]) begin
         @(posedge clk);
         wp_ok <= tbl[i][12];
         prot  <= tbl[i][11];
         repeat (4) @(posedge clk);
         pulse(mk(1'b1, fosr_pkg::fosr_op_e'(tbl[i][15:13]), 5'b0));
         g = tbl[i][12] & ~tbl[i][11];
         chk(go, g);
         @(posedge clk);
         wp_ok <= 1'b0; // supply drop after start must not count
         prot  <= 1'b0;
         if (g) begin
            repeat (3) @(posedge clk);
            fin(tbl[i][10:8], 1'b0);
         end
         fosr_host_model_inst.poll_ready(d, ok);
         chk(d, tbl[i][7:0]);
         clear_st();
      end
      @(posedge clk);
      wp_ok <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // protect accepts only read status while running
   task automatic t_protect();
      pulse(mk(1'b1, fosr_pkg::OP_PROTECT, 5'b0));
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00010), 8'h50);
      chk(ign, 1'b1);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00100), 8'h70);
      chk(ign, 1'b0);
      fin(3'b000, 1'b0);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h80);
   endtask

   // erase suspend with a program inside, then program suspend
   task automatic t_suspend();
      pulse(mk(1'b1, fosr_pkg::OP_ERASE, 5'b0));
      pulse(mk(1'b0, fosr_pkg::OP_NONE, 5'b10000));
      fosr_host_model_inst.read_stat(d, oe);
      chk(d[7], 1'b0);
      chk(susp, 1'b1);
      fin(3'b000, 1'b1);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'hC0);
      pulse(mk(1'b1, fosr_pkg::OP_PROGRAM, 5'b0));
      chk(go, 1'b1);
      fin(3'b000, 1'b0);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'hC0);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00001), 8'hFF);
      pulse(mk(1'b0, fosr_pkg::OP_NONE, 5'b01000));
      chk(stat_mode, 1'b1);
      fosr_host_model_inst.read_stat(d, oe);
      chk({d[7], resm}, 8'h01);
      fin(3'b000, 1'b0);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h80);
      pulse(mk(1'b1, fosr_pkg::OP_PROGRAM, 5'b0));
      pulse(mk(1'b0, fosr_pkg::OP_NONE, 5'b10000));
      fin(3'b000, 1'b1);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h84);
      pulse(mk(1'b0, fosr_pkg::OP_NONE, 5'b01000));
      fin(3'b000, 1'b0);
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h80);
   endtask

   // status read blocks burst reads; array read restores them
   task automatic t_read_mode();
      @(posedge clk);
      sync_cfg <= 1'b1;
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00001), 8'hFF);
      repeat (4) @(posedge clk);
      chk({stat_mode, sync_en}, 8'h01);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00100), 8'h70);
      repeat (2) @(posedge clk);
      chk({stat_mode, sync_en}, 8'h02);
      send(mk(1'b0, fosr_pkg::OP_NONE, 5'b00001), 8'hFF);
      repeat (2) @(posedge clk);
      chk(sync_en, 1'b1);
   endtask

   // hardware reset after a failed program start drops sticky errors
   task automatic t_hw_reset();
      @(posedge clk);
      wp_ok <= 1'b0;
      repeat (4) @(posedge clk);
      pulse(mk(1'b1, fosr_pkg::OP_PROGRAM, 5'b0));
      fosr_host_model_inst.poll_ready(d, ok);
      chk(d, 8'h98);
      @(posedge clk);
      rst   <= 1'b1;
      wp_ok <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(dq, 8'h80);
      repeat (2) @(posedge clk);
      #1;
      chk(dq, 8'h80);
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // cut a hang short
   initial begin
      #200000;
      errors++;
      wrap_up();
   end

   // reset, then the scenarios
   initial begin
      rst      = 1'b1;
      cmd      = '0;
      res      = '0;
      done     = 1'b0;
      paused   = 1'b0;
      prot     = 1'b0;
      wp_ok    = 1'b1;
      sync_cfg = 1'b0;
      errors   = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(dq, 8'h80);
      chk({7'h00, stat_mode}, 8'h00);
      repeat (3) @(posedge clk);
      t_erase_limit();
      t_causes();
      t_protect();
      t_suspend();
      t_read_mode();
      t_hw_reset();
      wrap_up();
   end
endmodule
